// >>> hw/temp_limit_consts.svh
// Purpose: numeric constants for the temperature limit interrupt logic
// Assumes: included by bare name from design files
// Notes: widths, field positions, reset values and the hysteresis zero pad only
`ifndef TEMP_LIMIT_CONSTS_SVH
`define TEMP_LIMIT_CONSTS_SVH

`define TEMP_RAW_W 12
`define TEMP_SP_W 8
`define TEMP_HYST_W 3
`define TEMP_FRAC_W 4
`define TEMP_LOW_RES_DROP 3
`define TEMP_NINE_MSB 8
`define TEMP_RESULT_RST 12'h000
`define TEMP_HYST_PAD 6'h00

`endif

// >>> hw/temp_limit_pkg.sv
// Purpose: types shared by the temperature limit interrupt logic
// Assumes: temp_limit_consts.svh supplies the widths
// Notes: mode encoding order is repetitive, one-time, comparator
`include "temp_limit_consts.svh"

package temp_limit_pkg;

    // interrupt behaviour within an option
    typedef enum logic [1:0] {MODE_REPEAT, MODE_ONCE, MODE_COMPARE} tempMode_t;

    // programmable setpoints, two's complement, hysteresis unsigned, 1 degree step
    typedef struct packed {
        logic [`TEMP_SP_W-1:0] upper;
        logic [`TEMP_SP_W-1:0] lower;
        logic [`TEMP_SP_W-1:0] critical;
        logic [`TEMP_SP_W-1:0] upperRelease;
        logic [`TEMP_HYST_W-1:0] hysteresis;
    } limits_t;

    // per-source mask bits, zero lets the flag through
    typedef struct packed {
        logic high;
        logic low;
    } mask_t;

    // whole state of the block
    typedef struct packed {
        tempMode_t mode;
        logic extended;
        logic [`TEMP_RAW_W-1:0] result;
        logic statHigh;
        logic statLow;
        logic hiCond;
        logic loCond;
        logic hiArmed;
        logic loArmed;
        logic critCond;
        logic critLatch;
        logic intN;
        logic critN;
    } state_t;

endpackage

// >>> hw/temp_limit_interrupt_logic.sv
// Purpose: format conversion results and raise general and critical interrupts
// Assumes: conversion results and control strobes come from logic on clk
// Notes: comparisons run in 1/16 degree units so both resolutions share them
//
// Behaviour
// R1: result is 9-bit or 12-bit two's complement
// R2: every result compared with all setpoints
// R3: setpoints are 8-bit two's complement degrees
// R4: default reading is 9-bit, half-degree steps
// R5: extended mode may report 12-bit sixteenth degrees
// R6: hysteresis is 3-bit unsigned degrees
// R7: normal and extended, each three behaviours
// R8: normal repetitive re-fires above upper release
// R9: normal one-time re-arms at upper release
// R10: reset selects normal one-time behaviour
// R11: normal comparator follows upper setpoint only
// R12: extended repetitive flags latch until status read
// R13: extended critical latch cleared by its read
// R14: extended repetitive low holds until low+hysteresis
// R15: extended repetitive high holds until upper-hysteresis
// R16: extended critical alert above critical limit
// R17: extended one-time low re-arms above upper
// R18: extended one-time high re-arms at upper-hysteresis
// R19: extended comparator low clears above low+hysteresis
// R20: extended comparator high clears at upper-hysteresis
// R21: flag drives interrupt only when mask zero
// R22: status read clears, new comparisons set again
// R23: critical releases at critical minus hysteresis
`include "temp_limit_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module temp_limit_interrupt_logic
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic convDone,
    input wire logic [`TEMP_RAW_W-1:0] convRaw,
    input wire logic modeWrite,
    input wire temp_limit_pkg::tempMode_t modeIn,
    input wire logic extendedIn,
    input wire logic resolution12,
    input wire temp_limit_pkg::limits_t limits,
    input wire temp_limit_pkg::mask_t mask,
    input wire logic status1Read,
    input wire logic extMode1Read,
    output logic [`TEMP_RAW_W-1:0] tempResult,
    output logic statusHigh,
    output logic statusLow,
    output logic int_n,
    output logic critical_alert_n
);
    import temp_limit_pkg::*;

    // scale a signed degree value to a 13-bit sixteenth-degree value
    function automatic logic signed [12:0] toSixteenths(input logic signed [8:0] deg);
        toSixteenths = $signed({deg, 4'h0});
    endfunction

    // widen an 8-bit setpoint to 9 bits so offsets cannot overflow
    function automatic logic signed [8:0] widen(input logic [`TEMP_SP_W-1:0] sp);
        widen = $signed({sp[`TEMP_SP_W-1], sp}); // R3
    endfunction

    // hysteresis as a positive 9-bit signed offset
    function automatic logic signed [8:0] hystOf(input logic [`TEMP_HYST_W-1:0] h);
        hystOf = $signed({`TEMP_HYST_PAD, h}); // R6
    endfunction

    state_t s_q; // registered state
    state_t s_d; // next state

    logic useFine; // twelve-bit resolution in force
    logic [`TEMP_RAW_W-1:0] tTrunc; // result with dropped fraction bits zeroed
    logic signed [12:0] t13; // signed result used by every comparison
    logic signed [8:0] relHiDeg; // upper release point in degrees
    logic tGtUpper; // result above upper setpoint
    logic tLeRelHi; // result at or below upper release point
    logic tLeLower; // result at or below lower setpoint
    logic tGtLowRel; // result above lower setpoint plus hysteresis
    logic tGtCrit; // result above critical limit
    logic tLeCritRel; // result at or below critical minus hysteresis
    logic latching; // repetitive or one-time behaviour selected

    // threshold compare, shared by all modes
    always_comb
    begin
        // fine resolution only exists in the extended option
        useFine = s_q.extended & resolution12; // R5
        tTrunc = convRaw;
        if (!useFine)
        begin
            // half-degree steps: drop the three lowest fraction bits
            tTrunc[`TEMP_LOW_RES_DROP-1:0] = 3'h0; // R4
        end
        t13 = $signed({tTrunc[`TEMP_RAW_W-1], tTrunc});
        // extended uses upper minus hysteresis, normal comparator the upper itself
        if (s_q.extended)
        begin
            relHiDeg = widen(limits.upper) - hystOf(limits.hysteresis); // R15 R18 R20
        end
        else if (s_q.mode == MODE_COMPARE)
        begin
            relHiDeg = widen(limits.upper); // R11
        end
        else
        begin
            relHiDeg = widen(limits.upperRelease); // R8 R9
        end
        // every conversion meets every threshold
        tGtUpper = t13 > toSixteenths(widen(limits.upper)); // R2
        tLeRelHi = t13 <= toSixteenths(relHiDeg);
        tLeLower = t13 <= toSixteenths(widen(limits.lower));
        tGtLowRel = t13 > toSixteenths(widen(limits.lower) + hystOf(limits.hysteresis)); // R14 R19
        tGtCrit = t13 > toSixteenths(widen(limits.critical)); // R16
        tLeCritRel = t13 <= toSixteenths(widen(limits.critical) - hystOf(limits.hysteresis)); // R23
        latching = (s_q.mode != MODE_COMPARE);
    end

    // next-state logic: reads clear first, then a conversion may set again
    always_comb
    begin
        s_d = s_q;
        // a mode change selects the pin source at once and the comparisons from the next conversion
        if (modeWrite)
        begin
            s_d.mode = modeIn; // R7
            s_d.extended = extendedIn;
        end
        // read clears both flags; a set below in the same cycle wins
        if (status1Read)
        begin
            s_d.statHigh = 1'b0; // R22
            s_d.statLow = 1'b0;
        end
        // critical latch has its own read, status reads leave it alone
        if (extMode1Read)
        begin
            s_d.critLatch = 1'b0; // R13
        end
        if (convDone)
        begin
            // R1: nine-bit value sign-extended, or full twelve bits
            if (useFine)
            begin
                s_d.result = convRaw;
            end
            else
            begin
                s_d.result = {{`TEMP_LOW_RES_DROP{convRaw[`TEMP_RAW_W-1]}},
                              convRaw[`TEMP_RAW_W-1:`TEMP_LOW_RES_DROP]}; // R4
            end
            // upper condition holds from crossing until the release point
            s_d.hiCond = tGtUpper | (s_q.hiCond & ~tLeRelHi); // R8 R15 R20
            // lower side exists only in the extended option
            s_d.loCond = s_q.extended & (tLeLower | (s_q.loCond & ~tGtLowRel)); // R11 R14 R19
            s_d.critCond = s_q.extended & (tGtCrit | (s_q.critCond & ~tLeCritRel)); // R16 R23
            unique case (s_q.mode)
                MODE_REPEAT:
                begin
                    // re-fires on every conversion while the condition holds
                    if (s_d.hiCond)
                    begin
                        s_d.statHigh = 1'b1; // R8 R12 R15
                    end
                    if (s_d.loCond)
                    begin
                        s_d.statLow = 1'b1; // R14
                    end
                end
                MODE_ONCE:
                begin
                    // one shot per excursion, upper shot re-armed by the release point
                    if (tGtUpper && s_q.hiArmed)
                    begin
                        s_d.statHigh = 1'b1; // R9
                        s_d.hiArmed = 1'b0;
                    end
                    else if (tLeRelHi)
                    begin
                        s_d.hiArmed = 1'b1; // R9 R18
                    end
                    // lower shot re-armed only by a result above the upper setpoint
                    if (s_q.extended && tLeLower && s_q.loArmed)
                    begin
                        s_d.statLow = 1'b1; // R17
                        s_d.loArmed = 1'b0;
                    end
                    else if (tGtUpper)
                    begin
                        s_d.loArmed = 1'b1; // R17
                    end
                end
                MODE_COMPARE:
                begin
                    // flags set while the conditions hold and clear only on a status read; the pin follows the conditions directly
                    if (s_d.hiCond)
                    begin
                        s_d.statHigh = 1'b1; // R11 R20
                    end
                    if (s_d.loCond)
                    begin
                        s_d.statLow = 1'b1; // R19
                    end
                end
                default:
                begin
                    // unused code: flags and arming bits hold, conditions, result and critical latch still update
                    s_d.hiArmed = s_q.hiArmed;
                end
            endcase
            // latching critical alert in repetitive and one-time
            if (latching && s_d.critCond)
            begin
                s_d.critLatch = 1'b1; // R13 R16
            end
        end
        // comparator pins follow conditions, latching modes follow flags
        if (s_d.mode == MODE_COMPARE)
        begin
            s_d.intN = ~((s_d.hiCond & ~mask.high) | (s_d.loCond & ~mask.low)); // R11 R19 R20 R21
            s_d.critN = ~(s_d.extended & s_d.critCond); // R16 R23
        end
        else
        begin
            s_d.intN = ~((s_d.statHigh & ~mask.high) | (s_d.statLow & ~mask.low)); // R21 R22
            s_d.critN = ~(s_d.extended & s_d.critLatch); // R8 R9 R13
        end
    end

    // state register; reset gives normal one-time, all flags clear
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_q.mode <= MODE_ONCE; // R10
            s_q.extended <= 1'b0; // R10
            s_q.result <= `TEMP_RESULT_RST;
            s_q.statHigh <= 1'b0;
            s_q.statLow <= 1'b0;
            s_q.hiCond <= 1'b0;
            s_q.loCond <= 1'b0;
            s_q.hiArmed <= 1'b1;
            s_q.loArmed <= 1'b1;
            s_q.critCond <= 1'b0;
            s_q.critLatch <= 1'b0;
            s_q.intN <= 1'b1;
            s_q.critN <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign tempResult = s_q.result;
    assign statusHigh = s_q.statHigh;
    assign statusLow = s_q.statLow;
    assign int_n = s_q.intN;
    assign critical_alert_n = s_q.critN;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // conversion events: critical in the extended option, upper violation in repetitive
    sequence extHotConv;
        convDone && s_q.extended && tGtCrit;
    endsequence

    sequence repeatAbove;
        convDone && (s_q.mode == MODE_REPEAT) && tGtUpper;
    endsequence

    a_reset_default_mode: assert property ($past(!rst_b) |-> (s_q.mode == MODE_ONCE) && !s_q.extended) // R10
        else $error("reset did not select normal one-time");
    a_read_clears_flags: assert property (status1Read && !convDone |=> !statusHigh && !statusLow) // R22
        else $error("status read did not clear flags");
    a_repeat_sets_high: assert property (repeatAbove |=> statusHigh) // R8
        else $error("repetitive mode missed upper violation");
    a_masked_int_quiet: assert property (mask.high && mask.low |=> int_n) // R21
        else $error("masked flags drove the interrupt");
    a_normal_no_crit: assert property (!s_q.extended |-> critical_alert_n) // R8
        else $error("critical alert active in normal option");
    a_crit_sets_cond: assert property (extHotConv ##1 !modeWrite |-> s_q.critCond) // R16
        else $error("critical condition not taken");
    a_crit_latch_holds: assert property (s_q.critLatch && !extMode1Read |=> s_q.critLatch) // R13
        else $error("critical latch dropped without its read");
    a_once_blocked: assert property (convDone && (s_q.mode == MODE_ONCE) && !s_q.hiArmed // R9
        && !tLeRelHi && !status1Read && !modeWrite |=> statusHigh == $past(statusHigh))
        else $error("one-time mode fired twice");
    a_nine_bit_form: assert property (convDone && !useFine |=> // R4
        tempResult[`TEMP_RAW_W-1:`TEMP_NINE_MSB] == {4{tempResult[`TEMP_NINE_MSB]}})
        else $error("nine-bit result not sign-extended");
    a_comp_low_follow: assert property (convDone && s_q.extended // R19
        && (s_q.mode == MODE_COMPARE) && tLeLower && !modeWrite && !mask.low ##1 !mask.low
        |-> !int_n)
        else $error("comparator low did not assert interrupt");

    // compare-mode conversion in the extended option, no mode load pending
    sequence extCompareConv;
        convDone && s_q.extended && (s_q.mode == MODE_COMPARE) && !modeWrite;
    endsequence

    // one-time conversion with no status read or mode load beside it
    sequence onceQuietConv;
        convDone && (s_q.mode == MODE_ONCE) && !status1Read && !modeWrite;
    endsequence

    // comparator pin follows the upper condition at once
    a_comp_high_follow: assert property (convDone && (s_q.mode == MODE_COMPARE) // R11 R20
        && !modeWrite && tGtUpper && !mask.high |=> !int_n)
        else $error("comparator high did not assert interrupt");
    // an armed one-time shot fires on an upper violation
    a_once_high_fire: assert property (convDone && (s_q.mode == MODE_ONCE) // R9
        && s_q.hiArmed && tGtUpper |=> statusHigh)
        else $error("armed one-time shot did not fire");
    // lower condition sets its flag in repetitive and comparator
    a_low_sets_flag: assert property (convDone && s_q.extended && tLeLower // R14 R19
        && (s_q.mode == MODE_REPEAT || s_q.mode == MODE_COMPARE) |=> statusLow)
        else $error("lower violation did not set its flag");
    // a spent lower shot cannot fire again before re-arming
    a_once_low_spent: assert property (onceQuietConv ##0 !s_q.loArmed // R17
        |=> statusLow == $past(statusLow))
        else $error("spent lower shot fired");
    // normal option never builds a lower condition
    a_normal_no_low: assert property (convDone && !s_q.extended |=> !s_q.loCond) // R11
        else $error("lower condition built in normal option");
    // comparator critical alert follows its condition both ways
    a_comp_crit_set: assert property (extCompareConv ##0 tGtCrit |=> !critical_alert_n) // R16
        else $error("comparator critical alert not raised");
    a_comp_crit_rel: assert property (extCompareConv ##0 tLeCritRel |=> critical_alert_n) // R23
        else $error("comparator critical alert not released");
    // its own read drops the critical latch
    a_crit_read_clears: assert property (extMode1Read && !convDone |=> !s_q.critLatch) // R13
        else $error("critical latch survived its read");
    // twelve-bit reading passes the raw value unchanged
    a_fine_passes_raw: assert property (convDone && useFine |=> // R5
        tempResult == $past(convRaw))
        else $error("twelve-bit result altered");

endmodule // temp_limit_interrupt_logic

`default_nettype wire

// >>> tb/test_temp_limit_interrupt_logic.sv
// Purpose: self-checking bench for the temperature limit interrupt logic
// Assumes: ports driven at the rising edge, outputs sampled 1 ns after it
// Notes: setpoints upper 50, lower 10, critical 80, upper release 45, hysteresis 3
`timescale 1ns/1ps
`default_nettype none

// one compare, counted; a mismatch prints at once
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
    $display("BAD %s exp %h seen %h", nm, ex, got); end end

module test_temp_limit_interrupt_logic;
    import temp_limit_pkg::*;

    logic clk; // 40 MHz
    logic rst_b; // synchronous, active low
    logic convDone;
    logic [11:0] convRaw; // sixteenths of a degree
    logic modeWrite;
    tempMode_t modeIn;
    logic extendedIn;
    logic resolution12;
    limits_t limits;
    mask_t mask;
    logic status1Read;
    logic extMode1Read;
    logic [11:0] tempResult;
    logic statusHigh;
    logic statusLow;
    logic int_n;
    logic critical_alert_n;
    int n_fail = 0;
    int cmp_count = 0;

    temp_limit_interrupt_logic i_temp_limit_interrupt_logic (
        .clk(clk), .rst_b(rst_b), .convDone(convDone), .convRaw(convRaw),
        .modeWrite(modeWrite), .modeIn(modeIn), .extendedIn(extendedIn),
        .resolution12(resolution12), .limits(limits), .mask(mask),
        .status1Read(status1Read), .extMode1Read(extMode1Read),
        .tempResult(tempResult), .statusHigh(statusHigh), .statusLow(statusLow),
        .int_n(int_n), .critical_alert_n(critical_alert_n)
    );

    // free-running clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // verdict, the single exit of the run
    task automatic test_done();
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one conversion pulse; result visible after the taking edge
    task automatic cvr(input logic [11:0] r);
        @(posedge clk);
        convDone <= 1'b1;
        convRaw <= r;
        @(posedge clk);
        convDone <= 1'b0;
        #1;
    endtask

    // conversion of a whole number of degrees
    task automatic cv(input int deg);
        cvr(12'(deg * 16));
    endtask

    // read pulse: status register 1, or extended mode register 1 when ext set
    task automatic rd(input bit ext);
        @(posedge clk);
        if (ext)
            extMode1Read <= 1'b1;
        else
            status1Read <= 1'b1;
        @(posedge clk);
        status1Read <= 1'b0;
        extMode1Read <= 1'b0;
        #1;
    endtask

    // mode load; conditions are kept across it, so scenarios start neutral
    task automatic setMode(input tempMode_t m, input logic e);
        @(posedge clk);
        modeWrite <= 1'b1;
        modeIn <= m;
        extendedIn <= e;
        @(posedge clk);
        modeWrite <= 1'b0;
    endtask

    // mask change, given two edges to land on the registered output
    task automatic setMask(input logic h, input logic l);
        @(posedge clk);
        mask <= '{high: h, low: l};
        repeat (2) @(posedge clk);
        #1;
    endtask

    // hang guard: far beyond the length of the sequence
    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        test_done();
    end

    // main sequence
    initial
    begin
        rst_b = 1'b0;
        convDone = 1'b0;
        convRaw = 12'h000;
        modeWrite = 1'b0;
        modeIn = MODE_REPEAT;
        extendedIn = 1'b0;
        resolution12 = 1'b0;
        limits = '{upper: 8'h32, lower: 8'h0A, critical: 8'h50, upperRelease: 8'h2D,
                   hysteresis: 3'h3};
        mask = '{high: 1'b0, low: 1'b0};
        status1Read = 1'b0;
        extMode1Read = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK("rst result", 12'h000, tempResult)
        `CHK("rst int", 1'b1, int_n)
        `CHK("rst crit", 1'b1, critical_alert_n)
        // default behaviour is normal one-time, 9-bit readings
        cvr(12'h7D8);
        `CHK("fmt 125.5", 12'h0FB, tempResult)
        `CHK("once fire", 1'b1, statusHigh)
        `CHK("once int", 1'b0, int_n)
        `CHK("normal crit", 1'b1, critical_alert_n)
        rd(1'b0);
        `CHK("read clr", 1'b0, statusHigh)
        `CHK("read int", 1'b1, int_n)
        cvr(12'h3C8);
        `CHK("fmt 60.5", 12'h079, tempResult)
        `CHK("once hold", 1'b0, statusHigh)
        cvr(12'hE77);
        `CHK("fmt neg", 12'hFCE, tempResult)
        `CHK("normal low", 1'b0, statusLow)
        cv(51);
        `CHK("once rearm", 1'b1, statusHigh)
        setMask(1'b1, 1'b0);
        `CHK("mask blocks", 1'b1, int_n)
        setMask(1'b0, 1'b0);
        `CHK("mask open", 1'b0, int_n)
        rd(1'b0);
        // normal repetitive: re-fires while above upper release
        setMode(MODE_REPEAT, 1'b0);
        cv(20);
        cv(60);
        rd(1'b0);
        cv(47);
        `CHK("rep refire", 1'b1, statusHigh)
        rd(1'b0);
        cv(45);
        `CHK("rep release", 1'b0, statusHigh)
        // normal comparator: follows upper setpoint only
        setMode(MODE_COMPARE, 1'b0);
        cv(51);
        `CHK("cmp above", 1'b0, int_n)
        cv(50);
        `CHK("cmp at", 1'b1, int_n)
        cv(5);
        `CHK("cmp low ign", 1'b1, int_n)
        // extended repetitive
        setMode(MODE_REPEAT, 1'b1);
        cv(20);
        rd(1'b0);
        cv(81);
        `CHK("ext crit", 1'b0, critical_alert_n)
        cv(20);
        rd(1'b0);
        `CHK("crit latched", 1'b0, critical_alert_n)
        `CHK("flag read", 1'b0, statusHigh)
        rd(1'b1);
        `CHK("crit read", 1'b1, critical_alert_n)
        cv(10);
        `CHK("low at", 1'b1, statusLow)
        setMask(1'b0, 1'b1);
        `CHK("mask low", 1'b1, int_n)
        setMask(1'b1, 1'b1);
        `CHK("mask both", 1'b1, int_n)
        setMask(1'b0, 1'b0);
        `CHK("mask low open", 1'b0, int_n)
        rd(1'b0);
        cv(13);
        `CHK("low held", 1'b1, statusLow)
        rd(1'b0);
        cv(14);
        `CHK("low release", 1'b0, statusLow)
        cv(51);
        rd(1'b0);
        cv(48);
        `CHK("high held", 1'b1, statusHigh)
        rd(1'b0);
        cv(47);
        `CHK("high release", 1'b0, statusHigh)
        // extended comparator with 12-bit readings
        setMode(MODE_COMPARE, 1'b1);
        resolution12 <= 1'b1;
        cv(30);
        cvr(12'h321);
        `CHK("fmt 12b", 12'h321, tempResult)
        `CHK("ecmp high", 1'b0, int_n)
        cv(47);
        `CHK("ecmp hrel", 1'b1, int_n)
        cv(9);
        `CHK("ecmp low", 1'b0, int_n)
        cv(13);
        `CHK("ecmp lheld", 1'b0, int_n)
        cv(14);
        `CHK("ecmp lrel", 1'b1, int_n)
        cv(81);
        cv(78);
        `CHK("crit held", 1'b0, critical_alert_n)
        cv(77);
        `CHK("crit rel", 1'b1, critical_alert_n)
        // extended one-time, back to 9-bit
        setMode(MODE_ONCE, 1'b1);
        resolution12 <= 1'b0;
        cv(40);
        cv(51);
        rd(1'b0);
        cv(10);
        `CHK("eonce low", 1'b1, statusLow)
        rd(1'b0);
        cv(10);
        `CHK("eonce lhold", 1'b0, statusLow)
        cv(51);
        `CHK("eonce hfire", 1'b1, statusHigh)
        rd(1'b0);
        cv(49);
        cv(52);
        `CHK("eonce hhold", 1'b0, statusHigh)
        cv(47);
        cv(51);
        `CHK("eonce hrearm", 1'b1, statusHigh)
        // negative lower setpoint, minus 40 degrees
        @(posedge clk);
        limits.lower <= 8'hD8;
        cv(-39);
        `CHK("neg above", 1'b0, statusLow)
        cvr(12'hD80);
        `CHK("fmt -40", 12'hFB0, tempResult)
        `CHK("neg at", 1'b1, statusLow)
        test_done();
    end
endmodule // test_temp_limit_interrupt_logic

`default_nettype wire
